// File: smla_top.sv
// step and direction input, amplifier enable and alarm led control
//
// Contract
// - each step pulse moves motor one step in the direction level's sense
// - disable input removes winding current; logic runs, position is kept
// - unconnected disable input reads as enabled; motor energised normally
// - no alarm: solid green when disabled, flashing green when enabled
// - alarm code repeats: first digit red flashes, second digit green
// - config fault flashes red continuously, motor stays enabled
// - stall shows one red one green, only when an encoder is fitted
// - move while disabled 12, ccw limit 21, cw limit 22
// - overtemperature 31, internal rail out of range 32
// - overvoltage 41, undervoltage 42, flash backup fault 43
// - overcurrent 51, open winding 61, bad encoder 62 (encoder only)
// - serial fault 71, flash memory fault 72
// - rail, overvoltage, overcurrent, open winding de-energise and latch
// - non-latching alarm clears itself thirty seconds after fault goes; here one shared timer clears all thirty seconds after the last soft fault goes
// - closed disable pair means disabled, open pair means enabled
`timescale 1ns/1ps
module smla_top #(
  parameter int TICK_CYCLES = int'(smla_pkg::TICK_CYC)
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic step_in,
  input wire logic dir_in,
  input wire logic amp_dis_in,
  input wire logic [13:0] fault_in,
  output smla_pkg::smla_mtr_t mtr_out,
  output smla_pkg::smla_led_t led_out
);

  // pin synchronisers: stage one feeds stage two only
  logic [16:0] pin_s1_ff;
  logic [16:0] pin_s2_ff;
  logic step_d_ff;
  logic [1:0] warm_ff; // set once stage two holds real pin levels
  logic step_s, dir_s, dis_s;
  logic [13:0] cond_s;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pin_s1_ff <= 17'h00000;
      pin_s2_ff <= 17'h00000;
      step_d_ff <= 1'h0;
      warm_ff <= 2'h0;
    end else begin
      pin_s1_ff <= {fault_in, amp_dis_in, dir_in, step_in};
      pin_s2_ff <= pin_s1_ff;
      step_d_ff <= pin_s2_ff[0];
      warm_ff <= {warm_ff[0], 1'h1};
    end
  end

  assign step_s = pin_s2_ff[0];
  assign dir_s = pin_s2_ff[1];
  assign dis_s = pin_s2_ff[2]; // high only with the pair closed
  assign cond_s = pin_s2_ff[16:3];

  // register and state storage
  logic ctrl_enc_ff;
  logic [31:0] pos_ff, nxt_pos;
  logic [14:0] alarm_ff, nxt_alarm;
  smla_pkg::smla_mtr_t mtr_ff;
  logic [14:0] tick_cnt_ff;
  logic tick_ff;
  logic [14:0] clr_cnt_ff, nxt_clr_cnt;
  logic pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;

  // enable decision and step edge
  logic step_rise, latched_any, energized, do_step;

  assign step_rise = step_s && !step_d_ff;
  assign latched_any = |(alarm_ff & smla_pkg::LATCH_MASK);
  // open pair (input low, incl. unconnected) keeps amplifiers on
  // stage reset value reads as open, so wait until real levels are through
  assign energized = warm_ff[1] && !dis_s && !latched_any;
  assign do_step = step_rise && energized;

  // position keeps counting only while energised
  assign nxt_pos = !do_step ? pos_ff :
                   dir_s ? pos_ff + 32'h0000_0001 :
                   pos_ff - 32'h0000_0001;

  // apb decode
  logic apb_acc, apb_hit, wr_go;
  logic wr_ctrl, wr_status;
  logic [31:0] rd_mux;

  assign apb_acc = psel_in && penable_in;
  assign apb_hit = (paddr_in == smla_pkg::REG_CTRL) ||
                   (paddr_in == smla_pkg::REG_STATUS) ||
                   (paddr_in == smla_pkg::REG_POS) ||
                   (paddr_in == smla_pkg::REG_STATE);
  assign wr_go = apb_acc && pready_ff && pwrite_in;
  assign wr_ctrl = wr_go && (paddr_in == smla_pkg::REG_CTRL);
  assign wr_status = wr_go && (paddr_in == smla_pkg::REG_STATUS);
  assign rd_mux =
    (paddr_in == smla_pkg::REG_CTRL) ? {31'h0000_0000, ctrl_enc_ff} :
    (paddr_in == smla_pkg::REG_STATUS) ? {17'h00000, alarm_ff} :
    (paddr_in == smla_pkg::REG_POS) ? pos_ff :
    (paddr_in == smla_pkg::REG_STATE) ?
      {29'h0000_0000, latched_any, energized, dis_s} :
    32'h0000_0000;

  // alarm sources; encoder alarms need an encoder fitted
  logic [13:0] enc_gate;
  logic [14:0] raw_set, sw_clr, auto_clr;
  logic soft_active, clr_fire;

  assign enc_gate = ctrl_enc_ff ? 14'h3FFF :
                    ~smla_pkg::ENC_MASK[13:0];
  // pins map 1:1 to codes ..move alarm comes from the step logic
  assign raw_set = {step_rise && !energized, cond_s & enc_gate};
  // latched alarms are immune to software clear
  assign sw_clr = wr_status ?
                  pwdata_in[14:0] & ~smla_pkg::LATCH_MASK : 15'h0000;
  assign soft_active = |(raw_set & ~smla_pkg::LATCH_MASK);
  assign clr_fire = tick_ff && (clr_cnt_ff == 15'h0001);
  assign auto_clr = clr_fire ? ~smla_pkg::LATCH_MASK : 15'h0000;
  // a new event wins over any clear in the same cycle
  assign nxt_alarm = raw_set | (alarm_ff & ~(sw_clr | auto_clr));

  // one shared hold-off timer: restarts while any soft fault persists
  assign nxt_clr_cnt =
    soft_active ? 15'(smla_pkg::CLR_TICKS) :
    (tick_ff && clr_cnt_ff != 15'h0000) ? clr_cnt_ff - 15'h0001 :
    clr_cnt_ff;

  // highest priority alarm and led mode
  function automatic logic [3:0] top_alarm(input logic [14:0] v);
    logic [3:0] idx;
    idx = 4'hF;
    for (int i = smla_pkg::NUM_ALARMS - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  logic [3:0] top_idx;
  logic [5:0] top_code;
  smla_pkg::smla_led_mode_t led_mode;

  assign top_idx = top_alarm(alarm_ff);
  assign top_code = smla_pkg::alarm_code(top_idx);
  assign led_mode =
    (alarm_ff == 15'h0000) ?
      (energized ? smla_pkg::LM_FLASH_G : smla_pkg::LM_SOLID_G) :
    (top_idx == 4'(smla_pkg::A_CONFIG)) ? smla_pkg::LM_FLASH_R :
    smla_pkg::LM_CODE;

  // millisecond tick divider
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      tick_cnt_ff <= 15'h0000;
      tick_ff <= 1'h0;
    end else begin
      tick_ff <= (tick_cnt_ff == 15'(TICK_CYCLES - 1));
      tick_cnt_ff <= (tick_cnt_ff == 15'(TICK_CYCLES - 1)) ?
                     15'h0000 : tick_cnt_ff + 15'h0001;
    end
  end

  // motor command, position and alarms
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pos_ff <= smla_pkg::POS_RST;
      alarm_ff <= 15'h0000;
      clr_cnt_ff <= 15'h0000;
      mtr_ff <= '0;
    end else begin
      pos_ff <= nxt_pos;
      alarm_ff <= nxt_alarm;
      clr_cnt_ff <= nxt_clr_cnt;
      mtr_ff.energize <= energized;
      mtr_ff.step <= do_step;
      mtr_ff.dir <= dir_s;
    end
  end

  // apb slave: answers one cycle into the access phase
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pready_ff <= 1'h0;
      pslverr_ff <= 1'h0;
      prdata_ff <= 32'h0000_0000;
      ctrl_enc_ff <= smla_pkg::CTRL_RST;
    end else begin
      pready_ff <= apb_acc && !pready_ff;
      pslverr_ff <= apb_acc && !pready_ff && !apb_hit;
      prdata_ff <= (apb_acc && !pready_ff && !pwrite_in) ?
                   rd_mux : 32'h0000_0000;
      if (wr_ctrl) begin
        ctrl_enc_ff <= pwdata_in[smla_pkg::CTRL_ENC_BIT];
      end
    end
  end

  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign mtr_out = mtr_ff;

  smla_led_seq u_led_seq (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .tick_in(tick_ff),
    .mode_in(led_mode),
    .red_n_in(top_code[5:3]),
    .grn_n_in(top_code[2:0]),
    .led_out(led_out)
  );

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence fwd_step_s;
    step_rise && energized && dir_s;
  endsequence

  sequence rev_step_s;
    step_rise && energized && !dir_s;
  endsequence

  step_fwd_a: assert property (
    fwd_step_s |=> pos_ff == $past(pos_ff) + 32'h0000_0001 && mtr_ff.step)
    else $error("forward step not counted");

  step_rev_a: assert property (
    rev_step_s |=> pos_ff == $past(pos_ff) - 32'h0000_0001 && !mtr_ff.dir)
    else $error("reverse step not counted");

  dis_cut_a: assert property (
    dis_s |=> !mtr_ff.energize)
    else $error("winding current kept while disabled");

  dis_hold_pos_a: assert property (
    !energized |=> $stable(pos_ff) && !mtr_ff.step)
    else $error("position moved while disabled");

  move_alarm_a: assert property (
    step_rise && !energized |=> alarm_ff[smla_pkg::A_MOVEDIS])
    else $error("move while disabled not flagged");

  open_enable_a: assert property (
    warm_ff[1] && !dis_s && !latched_any |=> mtr_out.energize)
    else $error("open disable pair did not energise");

  latch_hold_a: assert property (
    alarm_ff[smla_pkg::A_OVERCUR] |=> alarm_ff[smla_pkg::A_OVERCUR]
      && !mtr_ff.energize)
    else $error("latched alarm released or motor on");

  auto_clear_a: assert property (
    clr_fire && !soft_active |=>
      (alarm_ff & ~smla_pkg::LATCH_MASK) == 15'h0000)
    else $error("soft alarm not cleared after hold-off");

  config_run_a: assert property (
    alarm_ff[smla_pkg::A_CONFIG] && !dis_s && !latched_any
      |=> mtr_ff.energize)
    else $error("config alarm disabled motor");

  enc_gate_a: assert property (
    $rose(alarm_ff[smla_pkg::A_STALL]) |-> $past(ctrl_enc_ff))
    else $error("stall raised without encoder");

  enc_bad_a: assert property (
    $rose(alarm_ff[smla_pkg::A_ENCBAD]) |-> $past(ctrl_enc_ff))
    else $error("bad encoder raised without encoder");

  // latched flags drop only through reset
  latch_keep_a: assert property (
    ($past(alarm_ff) & ~alarm_ff & smla_pkg::LATCH_MASK) == 15'h0000)
    else $error("latched alarm dropped");

  latch_cut_a: assert property (
    latched_any |=> !mtr_ff.energize)
    else $error("latched alarm left motor on");

  // a clean rise at the second sync stage
  sequence pin_rise_s;
    !pin_s2_ff[0] ##1 pin_s2_ff[0];
  endsequence

  step_pulse_a: assert property (
    pin_rise_s ##0 energized |=> mtr_ff.step)
    else $error("accepted step not pulsed");

  step_only_a: assert property (
    mtr_ff.step |-> $past(energized) && $past(pin_s2_ff[0]) &&
      !$past(pin_s2_ff[0], 2))
    else $error("step pulse without an enabled rise");

  dir_track_a: assert property (
    mtr_ff.dir == $past(dir_s))
    else $error("direction output lags the pin");

  alarm_set_a: assert property (
    raw_set != 15'h0000 |=> (alarm_ff & $past(raw_set)) == $past(raw_set))
    else $error("alarm event lost");

  // overcurrent outranks every other flag
  led_prio_a: assert property (
    alarm_ff[smla_pkg::A_OVERCUR] |-> top_code == {3'h5, 3'h1})
    else $error("highest priority alarm not chosen");

  cfg_mode_a: assert property (
    alarm_ff == (15'h0001 << smla_pkg::A_CONFIG) |->
      led_mode == smla_pkg::LM_FLASH_R)
    else $error("config fault not flashing red");

  idle_mode_a: assert property (
    alarm_ff == 15'h0000 && !energized |->
      led_mode == smla_pkg::LM_SOLID_G)
    else $error("idle disabled drive not solid green");

  // the hold-off restarts from full in the cycle after the last fault
  sequence soft_gone_s;
    soft_active ##1 !soft_active;
  endsequence

  clr_reload_a: assert property (
    soft_gone_s |-> clr_cnt_ff == 15'(smla_pkg::CLR_TICKS))
    else $error("clear timer not reloaded");

  early_clr_a: assert property (
    (alarm_ff & ~smla_pkg::LATCH_MASK) != 15'h0000 &&
      clr_cnt_ff > 15'h0001 && !wr_status |=>
      (alarm_ff & ~smla_pkg::LATCH_MASK) != 15'h0000)
    else $error("soft alarm cleared before hold-off");

endmodule

// File: smla_pkg.sv
// shared constants, types and code table of the step input and alarm led block
package smla_pkg;

  // clock and timebase
  localparam longint CLK_HZ = 64'h0000_0000_0131_2D00; // 20 MHz
  localparam longint TICK_US = 64'h0000_0000_0000_03E8; // 1 ms led timebase
  localparam longint TICK_CYC = (TICK_US * CLK_HZ) / 64'h0000_0000_000F_4240;
  // non-latching alarm self-clear time, in seconds and in ticks
  localparam longint CLR_S = 64'h0000_0000_0000_001E; // 30 s
  localparam int CLR_TICKS = int'((CLR_S * 64'h0000_0000_000F_4240) / TICK_US);

  // flash timing in ticks (ms)
  localparam logic [10:0] FLASH_ON_T = 11'h0FA; // 250 ms
  localparam logic [10:0] FLASH_OFF_T = 11'h0FA; // 250 ms
  localparam logic [10:0] FLASH_GAP_T = 11'h3E8; // 1000 ms pause

  // alarm vector positions, lowest index has highest priority
  localparam int NUM_ALARMS = 15;
  localparam int A_OVERCUR = 0; // 51
  localparam int A_OPENWIND = 1; // 61
  localparam int A_OVERVOLT = 2; // 41
  localparam int A_RAIL = 3; // 32
  localparam int A_FLASHMEM = 4; // 72
  localparam int A_SERIAL = 5; // 71
  localparam int A_BACKUP = 6; // 43
  localparam int A_UNDERVOLT = 7; // 42
  localparam int A_OVERTEMP = 8; // 31
  localparam int A_ENCBAD = 9; // 62
  localparam int A_STALL = 10; // 11
  localparam int A_CWLIM = 11; // 22
  localparam int A_CCWLIM = 12; // 21
  localparam int A_CONFIG = 13; // 10
  localparam int A_MOVEDIS = 14; // 12
  localparam logic [14:0] LATCH_MASK = 15'h000F;
  localparam logic [14:0] ENC_MASK = 15'h0600;

  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_POS = 8'h08;
  localparam logic [7:0] REG_STATE = 8'h0C;
  localparam int CTRL_ENC_BIT = 0;
  localparam logic CTRL_RST = 1'h0;
  localparam logic [31:0] POS_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    LM_SOLID_G = 2'h0,
    LM_FLASH_G = 2'h1,
    LM_FLASH_R = 2'h2,
    LM_CODE = 2'h3
  } smla_led_mode_t;

  typedef struct packed {
    logic red;
    logic green;
  } smla_led_t;

  typedef struct packed {
    logic energize;
    logic step;
    logic dir;
  } smla_mtr_t;

  // red count in [5:3], green count in [2:0]
  function automatic logic [5:0] alarm_code(input logic [3:0] idx);
    logic [5:0] c;
    c = 6'h00;
    unique case (idx)
      4'h0: c = {3'h5, 3'h1};
      4'h1: c = {3'h6, 3'h1};
      4'h2: c = {3'h4, 3'h1};
      4'h3: c = {3'h3, 3'h2};
      4'h4: c = {3'h7, 3'h2};
      4'h5: c = {3'h7, 3'h1};
      4'h6: c = {3'h4, 3'h3};
      4'h7: c = {3'h4, 3'h2};
      4'h8: c = {3'h3, 3'h1};
      4'h9: c = {3'h6, 3'h2};
      4'hA: c = {3'h1, 3'h1};
      4'hB: c = {3'h2, 3'h2};
      4'hC: c = {3'h2, 3'h1};
      4'hD: c = {3'h1, 3'h0};
      4'hE: c = {3'h1, 3'h2};
      default: c = 6'h00;
    endcase
    return c;
  endfunction

endpackage

// File: smla_led_seq.sv
// led flash sequencer: plays one code, flash pattern or solid green
`timescale 1ns/1ps
module smla_led_seq (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic tick_in,
  input smla_pkg::smla_led_mode_t mode_in,
  input wire logic [2:0] red_n_in,
  input wire logic [2:0] grn_n_in,
  output smla_pkg::smla_led_t led_out
);

  typedef enum logic [2:0] {
    SQ_GAP = 3'h0,
    SQ_RED_ON = 3'h1,
    SQ_RED_OFF = 3'h2,
    SQ_GRN_ON = 3'h3,
    SQ_GRN_OFF = 3'h4
  } smla_seq_t;

  smla_seq_t state_ff, nxt_state;
  smla_pkg::smla_led_mode_t mode_ff, nxt_mode;
  logic [10:0] cnt_ff, nxt_cnt;
  logic [2:0] rem_ff, nxt_rem;
  logic [2:0] grn_ff, nxt_grn;
  smla_pkg::smla_led_t led_ff;
  logic step_w;
  logic code_w;

  assign step_w = tick_in && (cnt_ff == 11'h000);
  assign code_w = (mode_ff == smla_pkg::LM_CODE);

  // phase walk; mode is sampled only at the gap so a code plays out whole
  always_comb begin
    nxt_state = state_ff;
    nxt_mode = mode_ff;
    nxt_cnt = (tick_in && cnt_ff != 11'h000) ? cnt_ff - 11'h001 : cnt_ff;
    nxt_rem = rem_ff;
    nxt_grn = grn_ff;
    if (step_w) begin
      unique case (state_ff)
        SQ_GAP: begin
          nxt_mode = mode_in;
          nxt_rem = red_n_in;
          nxt_grn = grn_n_in;
          nxt_cnt = smla_pkg::FLASH_ON_T;
          if (mode_in == smla_pkg::LM_CODE ||
              mode_in == smla_pkg::LM_FLASH_R) begin
            nxt_state = SQ_RED_ON;
          end else begin
            nxt_state = SQ_GRN_ON;
          end
        end
        SQ_RED_ON: begin
          nxt_state = SQ_RED_OFF;
          nxt_cnt = smla_pkg::FLASH_OFF_T;
        end
        SQ_RED_OFF: begin
          nxt_cnt = smla_pkg::FLASH_ON_T;
          if (!code_w) begin
            nxt_state = SQ_GAP; // flash modes repeat with no pause
            nxt_cnt = 11'h000;
          end else if (rem_ff > 3'h1) begin
            nxt_state = SQ_RED_ON;
            nxt_rem = rem_ff - 3'h1;
          end else if (grn_ff == 3'h0) begin
            nxt_state = SQ_GAP;
            nxt_cnt = smla_pkg::FLASH_GAP_T;
          end else begin
            nxt_state = SQ_GRN_ON;
            nxt_rem = grn_ff;
          end
        end
        SQ_GRN_ON: begin
          nxt_state = SQ_GRN_OFF;
          nxt_cnt = smla_pkg::FLASH_OFF_T;
        end
        SQ_GRN_OFF: begin
          nxt_cnt = 11'h000;
          nxt_state = SQ_GAP;
          if (code_w && rem_ff > 3'h1) begin
            nxt_state = SQ_GRN_ON;
            nxt_rem = rem_ff - 3'h1;
            nxt_cnt = smla_pkg::FLASH_ON_T;
          end else if (code_w) begin
            nxt_cnt = smla_pkg::FLASH_GAP_T;
          end
        end
        default: nxt_state = SQ_GAP;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_ff <= SQ_GAP;
      mode_ff <= smla_pkg::LM_SOLID_G;
      cnt_ff <= 11'h000;
      rem_ff <= 3'h0;
      grn_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      mode_ff <= nxt_mode;
      cnt_ff <= nxt_cnt;
      rem_ff <= nxt_rem;
      grn_ff <= nxt_grn;
    end
  end

  // lamp drive; solid green ignores the flash phase
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      led_ff <= '0;
    end else begin
      led_ff.red <= (nxt_state == SQ_RED_ON);
      led_ff.green <= (nxt_state == SQ_GRN_ON) ||
                      (nxt_mode == smla_pkg::LM_SOLID_G);
    end
  end

  assign led_out = led_ff;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  lamps_exclusive_a: assert property (
    !(led_ff.red && led_ff.green))
    else $error("red and green lit together");

  solid_green_a: assert property (
    (nxt_mode == smla_pkg::LM_SOLID_G) |=> led_ff.green && !led_ff.red)
    else $error("solid green mode not shown");

endmodule

// File: smla_indexer.sv
// step and direction indexer model driving the drive's control pins
`timescale 1ns/1ps
module smla_indexer (
  input wire logic clk_in,
  output logic step_out,
  output logic dir_out
);
  // idle: step low, direction parked low
  initial begin
    step_out = 1'h0;
    dir_out = 1'h0;
  end

  // one pulse per step; dir settles a full hold before the first rise
  // hold sets both half periods, so fast and slow indexers are mimicked
  task automatic move(input int n, input logic d, input int hold);
    dir_out <= d;
    repeat (hold) @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      step_out <= 1'h1;
      repeat (hold) @(posedge clk_in);
      step_out <= 1'h0;
      repeat (hold) @(posedge clk_in);
    end
  endtask
endmodule

// File: smla_top_tb.sv
// self-checking bench: apb registers, step pins, faults and led codes
`timescale 1ns/1ps
module smla_top_tb;
  logic clk_in = 1'h0;
  logic rst_b_in = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic amp_dis = 1'h1;
  logic [13:0] fault_v = 14'h0000;
  logic step_w;
  logic dir_w;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  smla_pkg::smla_mtr_t mtr;
  smla_pkg::smla_led_t led;
  logic [31:0] rd;
  logic er;
  int err_total = 0;
  int tests_run = 0;
  int steps_seen = 0;
  int rr, gr, gon;
  // expected red and green digits, indexed by alarm position
  logic [7:0] codes [15] = '{8'h51, 8'h61, 8'h41, 8'h32, 8'h72, 8'h71,
    8'h43, 8'h42, 8'h31, 8'h62, 8'h11, 8'h22, 8'h21, 8'h10, 8'h12};

  always #25 clk_in = ~clk_in;

  // one-cycle led tick keeps code playback and the 30 s clear short
  smla_top #(.TICK_CYCLES(1)) u_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .step_in(step_w), .dir_in(dir_w),
    .amp_dis_in(amp_dis), .fault_in(fault_v), .mtr_out(mtr),
    .led_out(led)
  );

  smla_indexer u_idx (.clk_in(clk_in), .step_out(step_w), .dir_out(dir_w));

  // accepted steps as seen at the motor side
  always @(posedge clk_in) begin
    if (mtr.step === 1'h1) steps_seen++;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  // a wait that ran out of its bound ends the run
  task automatic tmo(input logic hung);
    if (hung) begin
      $display("mismatch timeout expected 0 seen 1");
      err_total++;
      print_verdict();
    end
  endtask

  task automatic rst();
    rst_b_in <= 1'h0;
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1'h1;
    repeat (4) @(posedge clk_in);
  endtask

  // one apb transfer; data and error taken at the pready edge only
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'h1 && n < 50);
    tmo(pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic watch(input int c);
    logic pr;
    logic pg;
    pr = led.red;
    pg = led.green;
    rr = 0;
    gr = 0;
    gon = 0;
    repeat (c) begin
      @(posedge clk_in);
      if (led.red === 1'h1 && pr !== 1'h1) rr++;
      if (led.green === 1'h1 && pg !== 1'h1) gr++;
      if (led.green === 1'h1) gon++;
      pr = led.red;
      pg = led.green;
    end
  endtask

  // lands 600 cycles into a dark pause, longer than any off time between flashes
  task automatic sync_gap();
    int n;
    int off;
    n = 0;
    off = 0;
    while (off < 600 && n < 20000) begin
      @(posedge clk_in);
      n++;
      off = (led === 2'h0) ? off + 1 : 0;
    end
    tmo(off < 600);
  endtask

  // counts one repetition from the end of a pause to the next pause
  task automatic measure(input logic [7:0] code);
    int n;
    int off;
    logic pr;
    logic pg;
    logic late;
    n = 0;
    while (led === 2'h0 && n < 3000) begin
      @(posedge clk_in);
      n++;
    end
    off = 0;
    rr = 0;
    gr = 0;
    pr = 1'h0;
    pg = 1'h0;
    late = 1'h0;
    while (off < 600 && n < 20000) begin
      if (led.red === 1'h1 && !pr) rr++;
      if (led.green === 1'h1 && !pg) gr++;
      if (led.red === 1'h1 && gr > 0) late = 1'h1;
      pr = led.red;
      pg = led.green;
      off = (led === 2'h0) ? off + 1 : 0;
      @(posedge clk_in);
      n++;
    end
    tmo(off < 600);
    chk("red flashes", {28'h0, code[7:4]}, 32'(rr));
    chk("green flashes", {28'h0, code[3:0]}, 32'(gr));
    chk("red after green", 32'h0, {31'h0, late});
  endtask

  initial begin
    rst();
    apb(1'h0, smla_pkg::REG_POS, 32'h0);
    chk("pos after reset", 32'h0, rd);
    apb(1'h0, smla_pkg::REG_STATE, 32'h0);
    chk("state closed pair", 32'h1, rd);
    repeat (1500) @(posedge clk_in);
    watch(1000);
    chk("solid green", 32'd1000, 32'(gon));
    apb(1'h0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    // config fault: red flashing, motor kept on
    amp_dis <= 1'h0;
    fault_v[13] <= 1'h1;
    fault_v[10:9] <= 2'h3;
    repeat (1500) @(posedge clk_in);
    watch(2000);
    chk("config red", 32'h1, 32'(rr >= 3));
    chk("config green", 32'h0, 32'(gr));
    chk("config energize", 32'h1, {31'h0, mtr.energize});
    // no encoder fitted: stall and encoder faults stay masked
    apb(1'h0, smla_pkg::REG_STATUS, 32'h0);
    chk("enc gated", 32'h2000, rd);
    fault_v <= 14'h0000;
    rst();
    // open pair reads as enabled; up then down through zero
    chk("energize open", 32'h1, {31'h0, mtr.energize});
    u_idx.move(3, 1'h1, 4);
    u_idx.move(5, 1'h0, 10);
    repeat (10) @(posedge clk_in);
    apb(1'h0, smla_pkg::REG_POS, 32'h0);
    chk("pos", 32'hFFFF_FFFE, rd);
    chk("step pulses", 32'd8, 32'(steps_seen));
    chk("dir", 32'h0, {31'h0, mtr.dir});
    // disable: current off, position kept, stray steps flagged
    amp_dis <= 1'h1;
    repeat (10) @(posedge clk_in);
    chk("energize closed", 32'h0, {31'h0, mtr.energize});
    u_idx.move(2, 1'h1, 4);
    repeat (10) @(posedge clk_in);
    apb(1'h0, smla_pkg::REG_POS, 32'h0);
    chk("pos kept", 32'hFFFF_FFFE, rd);
    chk("no pulses", 32'd8, 32'(steps_seen));
    apb(1'h0, smla_pkg::REG_STATUS, 32'h0);
    chk("move alarm", 32'h4000, rd);
    // encoder fitted so stall and encoder codes can show
    apb(1'h1, smla_pkg::REG_CTRL, 32'h1);
    sync_gap();
    measure(codes[14]);
    for (int i = 12; i >= 4; i--) begin
      fault_v[i] <= 1'h1;
      measure(codes[i]);
    end
    // shared clear timer: still set just before 30000 ticks, gone after
    fault_v <= 14'h0000;
    amp_dis <= 1'h0;
    repeat (29900) @(posedge clk_in);
    apb(1'h0, smla_pkg::REG_STATUS, 32'h0);
    chk("before clear", 32'h5FF0, rd);
    repeat (200) @(posedge clk_in);
    apb(1'h0, smla_pkg::REG_STATUS, 32'h0);
    chk("after clear", 32'h0, rd);
    // the code in play finishes before green flashing starts
    repeat (6000) @(posedge clk_in);
    watch(2000);
    chk("flash green", 32'h1, 32'(gr >= 3));
    chk("no red", 32'h0, 32'(rr));
    // latched rail fault survives its cause and a clear write
    fault_v[3] <= 1'h1;
    repeat (8) @(posedge clk_in);
    chk("latch energize", 32'h0, {31'h0, mtr.energize});
    // a refused step raises a soft flag that the clear write removes
    u_idx.move(1, 1'h1, 4);
    fault_v <= 14'h0000;
    apb(1'h1, smla_pkg::REG_STATUS, 32'h0000_7FFF);
    apb(1'h0, smla_pkg::REG_STATUS, 32'h0);
    chk("latched kept", 32'h0008, rd);
    apb(1'h0, smla_pkg::REG_STATE, 32'h0);
    chk("state latched", 32'h4, rd);
    sync_gap();
    measure(codes[3]);
    for (int i = 2; i >= 0; i--) begin
      fault_v[i] <= 1'h1;
      measure(codes[i]);
    end
    fault_v <= 14'h0000;
    apb(1'h0, smla_pkg::REG_STATUS, 32'h0);
    chk("all latched", 32'h000F, rd);
    print_verdict();
  end
endmodule
